// [logic/uepirq_consts.svh]
`ifndef UEPIRQ_CONSTS_SVH
`define UEPIRQ_CONSTS_SVH

// Register byte addresses (aligned words on the bus)
`define UEPIRQ_ADDR_FLAGS     8'h00
`define UEPIRQ_ADDR_ENABLES   8'h04
`define UEPIRQ_ADDR_DATA      8'h08
`define UEPIRQ_ADDR_COUNT     8'h0C
`define UEPIRQ_ADDR_SUMMARY   8'h10
`define UEPIRQ_ADDR_SELECT    8'h14
`define UEPIRQ_ADDR_CONFIG    8'h18

// Flag and enable bit positions
`define UEPIRQ_BIT_HSK        7
`define UEPIRQ_BIT_NAKIN      6
`define UEPIRQ_BIT_ACCESS     5
`define UEPIRQ_BIT_FLOWERR    7
`define UEPIRQ_BIT_NAKOUT     4
`define UEPIRQ_BIT_SETUP      3
`define UEPIRQ_BIT_OUT        2
`define UEPIRQ_BIT_STALL      1
`define UEPIRQ_BIT_TX         0

// Config register bits
`define UEPIRQ_BIT_DIR_IN     0
`define UEPIRQ_BIT_ISO        1

// Writable enable bits (bit 5 reserved)
`define UEPIRQ_ENABLE_MASK    8'hDF
`define UEPIRQ_RESET_BYTE     8'h00
`define UEPIRQ_FIFO_DEPTH     64
`define UEPIRQ_NUM_EP         5

`endif

// [logic/uepirq_pkg.sv]
package uepirq_pkg;
  typedef logic [7:0] uepirq_byte_type;
  typedef logic [2:0] uepirq_endpoint_select_type;
  typedef logic [5:0] uepirq_ptr_type;
endpackage

// [logic/uepirq_top.sv]
// What this block does
// - IN: handshake bit set with tx-ready
// - IN: firmware clear hands bank over
// - NAK to IN sets nak-in flag
// - NAK to OUT/PING sets nak-out flag
// - Access-allowed tracks bank not full/empty
// - Access-allowed low on stall or error
// - SETUP packet sets setup flag, not IN
// - Received OUT packet sets out flag
// - Event flags: hardware sets, zero clears
// - Kill-bank request: set by firmware, hardware clears
// - STALL sent or iso CRC error sets stall
// - Free bank sets tx-ready, not OUT
// - Flow-error enable gates iso overflow/underflow
// - Each enable but flow-error bit 7 gates its matching flag; bit 2 only on OUT endpoints
// - Data port moves one FIFO byte
// - IN count: writes up, sends down
// - OUT count: receives up, reads down
// - Summary holds one bit per endpoint
// - Reserved bits read zero
// - OUT/SETUP: handshake set on stored packet
`timescale 1ns/1ps
`include "uepirq_consts.svh"
module uepirq_top
  import uepirq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  usb_ep,
  input  wire logic        usb_nak_in,
  input  wire logic        usb_nak_out,
  input  wire logic        usb_setup_done,
  input  wire logic        usb_out_done,
  input  wire logic        usb_stall_sent,
  input  wire logic        usb_crc_err,
  input  wire logic        usb_rx_valid,
  input  wire logic [7:0]  usb_rx_byte,
  input  wire logic        usb_tx_take,
  input  wire logic        usb_tx_done,
  input  wire logic        stall_request,
  input  wire logic        iso_overflow_flag,
  input  wire logic        iso_underflow_flag,
  output logic      [7:0]  usb_tx_byte,
  output logic             usb_bank_ready,
  output logic      [4:0]  endpoint_irq
);

  localparam int NEP = `UEPIRQ_NUM_EP;

  uepirq_byte_type  flags_r   [NEP];
  uepirq_byte_type  enables_r [NEP];
  uepirq_byte_type  count_r   [NEP];
  uepirq_ptr_type   rptr_r    [NEP];
  uepirq_ptr_type   wptr_r    [NEP];
  uepirq_byte_type  fifo_r    [NEP][`UEPIRQ_FIFO_DEPTH];
  logic [1:0]       config_r  [NEP];
  uepirq_endpoint_select_type endpoint_select_r;
  logic [4:0]       summary_r;
  logic [4:0]       irq_nxt;

  // Bus phase decode; slave always answers in the access cycle
  logic acc;
  logic wr;
  logic rd;
  logic sel_ok;
  logic mapped;
  uepirq_endpoint_select_type sel;
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign sel    = endpoint_select_r;
  assign sel_ok = sel < 3'(NEP);
  assign mapped = (paddr == `UEPIRQ_ADDR_FLAGS) | (paddr == `UEPIRQ_ADDR_ENABLES) |
                  (paddr == `UEPIRQ_ADDR_DATA) | (paddr == `UEPIRQ_ADDR_COUNT) |
                  (paddr == `UEPIRQ_ADDR_SUMMARY) | (paddr == `UEPIRQ_ADDR_SELECT) |
                  (paddr == `UEPIRQ_ADDR_CONFIG);

  logic wr_flags;
  logic wr_data;
  logic rd_data;
  assign wr_flags = wr & (paddr == `UEPIRQ_ADDR_FLAGS) & sel_ok;
  assign wr_data  = wr & (paddr == `UEPIRQ_ADDR_DATA) & sel_ok;
  assign rd_data  = rd & (paddr == `UEPIRQ_ADDR_DATA) & sel_ok;

  // Endpoint select register; config lives in the per-endpoint block
  always_ff @(posedge clock) begin
    if (srst) begin
      endpoint_select_r <= 3'h0;
    end else if (wr & (paddr == `UEPIRQ_ADDR_SELECT)) begin
      endpoint_select_r <= pwdata[2:0];
    end
  end

  // Per-endpoint state; one loop keeps the five endpoints identical
  always_ff @(posedge clock) begin
    for (int e = 0; e < NEP; e++) begin
      logic is_in;
      logic here;
      logic me;
      logic full;
      logic empty;
      logic wz;
      logic [7:0] cnt;
      is_in = config_r[e][`UEPIRQ_BIT_DIR_IN];
      here  = (usb_ep == 3'(e));
      me    = (sel == 3'(e));
      cnt   = count_r[e];
      full  = (cnt == 8'(`UEPIRQ_FIFO_DEPTH));
      empty = (cnt == 8'h00);
      wz    = wr_flags & me;
      if (srst) begin
        flags_r[e]   <= `UEPIRQ_RESET_BYTE;
        enables_r[e] <= `UEPIRQ_RESET_BYTE;
        count_r[e]   <= `UEPIRQ_RESET_BYTE;
        rptr_r[e]    <= 6'h00;
        wptr_r[e]    <= 6'h00;
        config_r[e]  <= 2'h0;
      end else begin
        if (wr & me & (paddr == `UEPIRQ_ADDR_ENABLES)) begin
          enables_r[e] <= pwdata[7:0] & `UEPIRQ_ENABLE_MASK;
        end
        if (wr & me & (paddr == `UEPIRQ_ADDR_CONFIG)) begin
          config_r[e] <= pwdata[1:0];
        end
        // Software writes zero to clear; set wins over clear
        for (int b = 0; b < 8; b++) begin
          if (b != `UEPIRQ_BIT_ACCESS && b != `UEPIRQ_BIT_OUT && wz && !pwdata[b]) begin
            flags_r[e][b] <= 1'b0;
          end
        end
        if (wz && !pwdata[`UEPIRQ_BIT_OUT] && !is_in) begin
          flags_r[e][`UEPIRQ_BIT_OUT] <= 1'b0;
        end
        if (here && usb_nak_in) begin
          flags_r[e][`UEPIRQ_BIT_NAKIN] <= 1'b1;
        end
        if (here && usb_nak_out) begin
          flags_r[e][`UEPIRQ_BIT_NAKOUT] <= 1'b1;
        end
        if (here && (usb_stall_sent ||
                     (usb_crc_err && config_r[e][`UEPIRQ_BIT_ISO] && !is_in))) begin
          flags_r[e][`UEPIRQ_BIT_STALL] <= 1'b1;
        end
        if (here && usb_setup_done && !is_in) begin
          flags_r[e][`UEPIRQ_BIT_SETUP] <= 1'b1;
          flags_r[e][`UEPIRQ_BIT_HSK]   <= 1'b1;
        end
        if (here && usb_out_done && !is_in) begin
          flags_r[e][`UEPIRQ_BIT_OUT] <= 1'b1;
          flags_r[e][`UEPIRQ_BIT_HSK] <= 1'b1;
        end
        // Kill request: ones set it, hardware drops the last bank
        if (is_in && wz && pwdata[`UEPIRQ_BIT_OUT]) begin
          flags_r[e][`UEPIRQ_BIT_OUT] <= 1'b1;
        end
        if (is_in && flags_r[e][`UEPIRQ_BIT_OUT]) begin
          flags_r[e][`UEPIRQ_BIT_OUT] <= 1'b0;
          wptr_r[e] <= rptr_r[e];
          count_r[e] <= 8'h00;
          flags_r[e][`UEPIRQ_BIT_TX]  <= 1'b1;
          flags_r[e][`UEPIRQ_BIT_HSK] <= 1'b1;
        end
        // IN bank free after transmission: ready and handshake together
        if (here && usb_tx_done && is_in) begin
          flags_r[e][`UEPIRQ_BIT_TX]  <= 1'b1;
          flags_r[e][`UEPIRQ_BIT_HSK] <= 1'b1;
        end
        // Access flag follows bank level, never with stall or error
        flags_r[e][`UEPIRQ_BIT_ACCESS] <= !stall_request && !iso_overflow_flag &&
          !iso_underflow_flag && (is_in ? !full : !empty);
        if (!is_in) begin
          flags_r[e][`UEPIRQ_BIT_TX] <= 1'b0;
        end
        // FIFO and counter; the single bank is the ring buffer itself
        if (!(is_in && flags_r[e][`UEPIRQ_BIT_OUT])) begin
          logic up;
          logic dn;
          up = is_in ? (wr_data && me && !full) : (here && usb_rx_valid && !full);
          dn = is_in ? (here && usb_tx_take && !empty) : (rd_data && me && !empty);
          if (up) begin
            wptr_r[e] <= wptr_r[e] + 6'h01;
          end
          if (dn) begin
            rptr_r[e] <= rptr_r[e] + 6'h01;
          end
          count_r[e] <= cnt + {7'h00, up} - {7'h00, dn};
        end
      end
    end
  end

  // FIFO storage writes: from bus for IN, from host for OUT
  always_ff @(posedge clock) begin
    for (int e = 0; e < NEP; e++) begin
      if (config_r[e][`UEPIRQ_BIT_DIR_IN]) begin
        if (wr_data && sel == 3'(e) && count_r[e] != 8'(`UEPIRQ_FIFO_DEPTH)) begin
          fifo_r[e][wptr_r[e]] <= pwdata[7:0];
        end
      end else if (usb_rx_valid && usb_ep == 3'(e) && count_r[e] != 8'(`UEPIRQ_FIFO_DEPTH)) begin
        fifo_r[e][wptr_r[e]] <= usb_rx_byte;
      end
    end
  end

  // Firmware clear of handshake bit hands bank to host
  always_ff @(posedge clock) begin
    if (srst) begin
      usb_bank_ready <= 1'b0;
    end else begin
      usb_bank_ready <= wr_flags && !pwdata[`UEPIRQ_BIT_HSK] &&
                        flags_r[sel][`UEPIRQ_BIT_HSK];
    end
  end

  // Byte offered to the transmitter of the addressed endpoint
  always_ff @(posedge clock) begin
    if (srst) begin
      usb_tx_byte <= 8'h00;
    end else if (usb_ep < 3'(NEP)) begin
      usb_tx_byte <= fifo_r[usb_ep][rptr_r[usb_ep]];
    end
  end

  // Interrupt combine per endpoint
  always_comb begin
    for (int e = 0; e < NEP; e++) begin
      irq_nxt[e] = |(flags_r[e][4:0] & enables_r[e][4:0] & 5'h1B) |
                   (flags_r[e][`UEPIRQ_BIT_OUT] & enables_r[e][`UEPIRQ_BIT_OUT] &
                    ~config_r[e][`UEPIRQ_BIT_DIR_IN]) | // Bit 2 is the kill request on IN
                   (flags_r[e][`UEPIRQ_BIT_NAKIN] & enables_r[e][`UEPIRQ_BIT_NAKIN]) |
                   (enables_r[e][`UEPIRQ_BIT_FLOWERR] &
                    (iso_overflow_flag | iso_underflow_flag));
    end
  end

  // Summary follows the sources, clearing when serviced
  always_ff @(posedge clock) begin
    if (srst) begin
      summary_r    <= 5'h00;
      endpoint_irq <= 5'h00;
    end else begin
      summary_r    <= irq_nxt;
      endpoint_irq <= irq_nxt;
    end
  end

  // Read mux; register reads answer in the access cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~pready;
      pslverr <= psel & ~pready & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel & ~pwrite & ~pready & sel_ok) begin
        case (paddr)
          `UEPIRQ_ADDR_FLAGS:   prdata[7:0] <= flags_r[sel];
          `UEPIRQ_ADDR_ENABLES: prdata[7:0] <= enables_r[sel];
          `UEPIRQ_ADDR_DATA:    prdata[7:0] <= fifo_r[sel][rptr_r[sel]];
          `UEPIRQ_ADDR_COUNT:   prdata[7:0] <= count_r[sel];
          `UEPIRQ_ADDR_CONFIG:  prdata[1:0] <= config_r[sel];
          default:              prdata[7:0] <= 8'h00;
        endcase
      end
      if (psel & ~pwrite & ~pready) begin
        if (paddr == `UEPIRQ_ADDR_SUMMARY) prdata[4:0] <= summary_r;
        if (paddr == `UEPIRQ_ADDR_SELECT)  prdata[2:0] <= endpoint_select_r;
      end
    end
  end

  // Assertions
  property p_nakin;
    @(posedge clock) disable iff (srst)
    usb_nak_in && usb_ep == 3'h1 |=> flags_r[1][`UEPIRQ_BIT_NAKIN];
  endproperty
  a_nakin: assert property (p_nakin)
    else $error("nak in flag not set");
  property p_nakout;
    @(posedge clock) disable iff (srst)
    usb_nak_out && usb_ep == 3'h1 |=> flags_r[1][`UEPIRQ_BIT_NAKOUT];
  endproperty
  a_nakout: assert property (p_nakout)
    else $error("nak out flag not set");
  property p_acc_stall;
    @(posedge clock) disable iff (srst)
    stall_request |=> !flags_r[2][`UEPIRQ_BIT_ACCESS];
  endproperty
  a_acc_stall: assert property (p_acc_stall)
    else $error("access allowed during stall");
  // Endpoint 2 turns from IN to OUT late in the run; the $past term keeps this one quiet
  property p_tx_out;
    @(posedge clock) disable iff (srst)
    !config_r[2][`UEPIRQ_BIT_DIR_IN] && !$past(config_r[2][`UEPIRQ_BIT_DIR_IN]) |->
      !flags_r[2][`UEPIRQ_BIT_TX];
  endproperty
  a_tx_out: assert property (p_tx_out)
    else $error("tx ready on out endpoint");
  // With every enable of endpoint 1 clear nothing may reach its summary bit
  property p_sum;
    @(posedge clock) disable iff (srst)
    enables_r[1] == 8'h00 |=> !summary_r[1];
  endproperty
  a_sum: assert property (p_sum)
    else $error("summary bit without enable");
  property p_resv;
    @(posedge clock) disable iff (srst)
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits nonzero");
  property p_ready;
    @(posedge clock) disable iff (srst)
    psel && !pready |=> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("no bus answer");
  property p_out;
    @(posedge clock) disable iff (srst)
    usb_out_done && usb_ep == 3'h1 && !config_r[1][`UEPIRQ_BIT_DIR_IN] |=>
      flags_r[1][`UEPIRQ_BIT_OUT] && flags_r[1][`UEPIRQ_BIT_HSK];
  endproperty
  a_out: assert property (p_out)
    else $error("out flag or handshake not set");
  property p_irq_out;
    @(posedge clock) disable iff (srst)
    !config_r[1][`UEPIRQ_BIT_DIR_IN] && flags_r[1][`UEPIRQ_BIT_OUT] &&
      enables_r[1][`UEPIRQ_BIT_OUT] |=> endpoint_irq[1];
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("enabled out flag raised no interrupt");
  // A pending kill empties the bank on the very next edge
  property p_kill;
    @(posedge clock) disable iff (srst)
    config_r[2][`UEPIRQ_BIT_DIR_IN] && flags_r[2][`UEPIRQ_BIT_OUT] |=>
      !flags_r[2][`UEPIRQ_BIT_OUT] && count_r[2] == 8'h00;
  endproperty
  a_kill: assert property (p_kill)
    else $error("kill request not completed");
  c_irq: cover property (@(posedge clock) endpoint_irq != 5'h00);
  c_setup: cover property (@(posedge clock) usb_setup_done);
  c_kill: cover property (@(posedge clock) wr_flags && pwdata[`UEPIRQ_BIT_OUT]);
  c_bank: cover property (@(posedge clock) usb_bank_ready);

endmodule

// [tb/uepirq_host_model.sv]
`timescale 1ns/1ps
module uepirq_host_model (
  input  wire logic       clock,
  output logic      [2:0] usb_ep,
  output logic      [7:0] usb_ev,
  output logic            usb_rx_valid,
  output logic      [7:0] usb_rx_byte
);
  // Idle host: no transaction outcome on the wire
  initial begin
    usb_ep = 3'h0;
    usb_ev = 8'h00;
    usb_rx_valid = 1'b0;
    usb_rx_byte = 8'h00;
  end
  // One transaction outcome as a one-cycle pulse on one endpoint
  task automatic ev(input int k, input logic [2:0] ep);
    @(posedge clock);
    usb_ep <= ep;
    usb_ev[k] <= 1'b1;
    @(posedge clock);
    usb_ev <= 8'h00;
  endtask
  // One received byte; afterwards the line shows the inverse, never a stale copy
  task automatic rx(input logic [2:0] ep, input logic [7:0] b);
    @(posedge clock);
    usb_ep <= ep;
    usb_rx_valid <= 1'b1;
    usb_rx_byte <= b;
    @(posedge clock);
    usb_rx_valid <= 1'b0;
    usb_rx_byte <= ~b;
  endtask
endmodule

// [tb/uepirq_top_test.sv]
`timescale 1ns/1ps
module uepirq_top_test;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr;
  logic        stall_request, iso_overflow_flag, iso_underflow_flag;
  logic        usb_rx_valid, usb_bank_ready;
  logic [7:0]  paddr, usb_ev, usb_rx_byte, usb_tx_byte;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  usb_ep;
  logic [4:0]  endpoint_irq;
  logic        e;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          n_bank_ready = 0;

  uepirq_top uepirq_top_i (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_ep(usb_ep), .usb_nak_in(usb_ev[0]), .usb_nak_out(usb_ev[1]),
    .usb_setup_done(usb_ev[2]), .usb_out_done(usb_ev[3]), .usb_stall_sent(usb_ev[4]),
    .usb_crc_err(usb_ev[5]), .usb_rx_valid(usb_rx_valid), .usb_rx_byte(usb_rx_byte),
    .usb_tx_take(usb_ev[6]), .usb_tx_done(usb_ev[7]), .stall_request(stall_request),
    .iso_overflow_flag(iso_overflow_flag), .iso_underflow_flag(iso_underflow_flag),
    .usb_tx_byte(usb_tx_byte), .usb_bank_ready(usb_bank_ready),
    .endpoint_irq(endpoint_irq));
  uepirq_host_model uepirq_host_model_i (.clock(clock), .usb_ep(usb_ep), .usb_ev(usb_ev),
    .usb_rx_valid(usb_rx_valid), .usb_rx_byte(usb_rx_byte));

  // 100 ns system clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hand-over pulse lasts one cycle, too short for a bus read to catch
  always @(posedge clock) begin
    if (usb_bank_ready === 1'b1) begin
      n_bank_ready <= n_bank_ready + 1;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, s, x);
    end
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // APB transfer; entered and left just after a rising edge, one idle cycle between
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  // Byte read, compared under a mask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    apb(1'b0, a, 32'h00000000);
    chk({24'h000000, q[7:0] & m}, {24'h000000, x}, "register read");
  endtask

  task automatic t_reset;
    rd(8'h04, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
    apb(1'b0, 8'h1C, 32'h00000000);
    chk({31'h0, e}, 32'h1, "unmapped refusal");
    chk(q, 32'h0, "unmapped read data");
  endtask

  task automatic t_enables;
    wr(8'h14, 8'h01);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'hDF);
  endtask

  // OUT packet of three bytes on endpoint 1, then firmware service
  task automatic t_out;
    wr(8'h18, 8'h00);
    wr(8'h04, 8'h00);
    uepirq_host_model_i.rx(3'h1, 8'hA1);
    uepirq_host_model_i.rx(3'h1, 8'hB2);
    uepirq_host_model_i.rx(3'h1, 8'hC3);
    uepirq_host_model_i.ev(3, 3'h1);
    @(posedge clock);
    rd(8'h0C, 8'h03);
    rd(8'h00, 8'hA4);
    chk({27'h0, endpoint_irq}, 32'h0, "masked irq");
    wr(8'h04, 8'h04);
    rd(8'h10, 8'h02);
    chk({27'h0, endpoint_irq}, 32'h2, "irq line");
    rd(8'h08, 8'hA1);
    rd(8'h0C, 8'h02);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hA4);
    wr(8'h00, 8'hFB);
    rd(8'h00, 8'h00, 8'h04);
    rd(8'h10, 8'h00);
  endtask

  // Nak-in, nak-out, setup and stall each set their own flag; only the enabled one reaches the summary
  task automatic t_evt;
    int          k[4] = '{0, 1, 2, 4};
    logic [7:0]  b[4] = '{8'h40, 8'h10, 8'h08, 8'h02};
    wr(8'h04, 8'h10);
    for (int i = 0; i < 4; i++) begin
      uepirq_host_model_i.ev(k[i], 3'h1);
      @(posedge clock);
      rd(8'h00, b[i], b[i]);
    end
    rd(8'h10, 8'h02);
    wr(8'h04, 8'h00);
    rd(8'h10, 8'h00);
  endtask

  // IN endpoint 2: bank free, fill, hand over, send, stall gate, discard, flow error
  task automatic t_in;
    wr(8'h14, 8'h02);
    wr(8'h18, 8'h01);
    uepirq_host_model_i.ev(7, 3'h2);
    @(posedge clock);
    rd(8'h00, 8'hA1);
    wr(8'h08, 8'h5A);
    wr(8'h08, 8'h6B);
    rd(8'h0C, 8'h02);
    chk({24'h0, usb_tx_byte}, 32'h5A, "fifo head");
    wr(8'h00, 8'h7B);
    rd(8'h00, 8'h00, 8'h80);
    chk(n_bank_ready, 32'h1, "bank hand-over pulse");
    uepirq_host_model_i.ev(6, 3'h2);
    @(posedge clock);
    rd(8'h0C, 8'h01);
    stall_request <= 1'b1;
    @(posedge clock);
    rd(8'h00, 8'h00, 8'h20);
    stall_request <= 1'b0;
    wr(8'h00, 8'hFF);
    rd(8'h0C, 8'h00);
    rd(8'h00, 8'h00, 8'h04);
    wr(8'h18, 8'h03);
    wr(8'h04, 8'h80);
    iso_overflow_flag <= 1'b1;
    repeat (2) @(posedge clock);
    chk({31'h0, endpoint_irq[2]}, 32'h1, "overflow irq");
    iso_overflow_flag <= 1'b0;
    repeat (2) @(posedge clock);
    chk({31'h0, endpoint_irq[2]}, 32'h0, "flow error gone");
    iso_underflow_flag <= 1'b1;
    repeat (2) @(posedge clock);
    chk({31'h0, endpoint_irq[2]}, 32'h1, "underflow irq");
    wr(8'h04, 8'h00);
    @(posedge clock);
    chk({31'h0, endpoint_irq[2]}, 32'h0, "flow error masked");
    iso_underflow_flag <= 1'b0;
    wr(8'h18, 8'h02);
    uepirq_host_model_i.ev(5, 3'h2);
    @(posedge clock);
    rd(8'h00, 8'h02, 8'h03);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    stall_request = 1'b0;
    iso_overflow_flag = 1'b0;
    iso_underflow_flag = 1'b0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_enables;
    t_out;
    t_evt;
    t_in;
    report_and_stop;
  end

  // Hang guard, far beyond the few hundred cycles the scenarios need
  initial begin
    #(3000 * 100);
    n_mismatch++;
    report_and_stop;
  end
endmodule
